// ---- hli_pkg.sv ----
// Purpose: shared constants for the second link controller interrupt block
// Assumes: one clock, registers reached over a plain strobe port
// Notes:   offsets, bit positions, reset values and patterns live here only
package hli_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets on the plain register port
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h16;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h17;
    localparam logic [7:0] OFS_PENDING      = 8'h18;

    // status and enable bit positions (same layout in both registers)
    localparam int unsigned BIT_MSG_TYPE   = 7;
    localparam int unsigned BIT_TX_START   = 6;
    localparam int unsigned BIT_RX_START   = 5;
    localparam int unsigned BIT_TX_END     = 4;
    localparam int unsigned BIT_RX_END     = 3;
    localparam int unsigned BIT_FCS_ERR    = 2;
    localparam int unsigned BIT_ABORT      = 1;
    localparam int unsigned BIT_FLAG_OCTET = 0;

    // number of sticky event flags (bits 6..0)
    localparam int unsigned NUM_EVENTS = 7;

    // reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_RDATA  = 8'h00;

    // writable enable bits; bit 7 is reserved and stays zero
    localparam logic [7:0] ENABLE_RW_MASK = 8'h7f;

    // incoming data link channel patterns
    localparam logic [7:0] FLAG_OCTET     = 8'h7e;
    localparam int unsigned ABORT_ONES    = 7;

endpackage : hli_pkg

// ---- hli_flag_bank.sv ----
// Purpose: bank of sticky event flags with set-over-clear priority
// Assumes: set and clear are single-cycle masks in the mclk domain
// Notes:   a flag set and cleared in one cycle stays set, so no event is lost
`timescale 1ns/10ps
`default_nettype none
module hli_flag_bank #(
    parameter int unsigned WIDTH = 7
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // event side
    input  wire logic [WIDTH-1:0] set_mask,
    // software side
    input  wire logic [WIDTH-1:0] clr_mask,
    output logic      [WIDTH-1:0] flags
);

    if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
        $error("hli_flag_bank: WIDTH must be 1 to 8");
    end

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } hli_bank_state_t;

    hli_bank_state_t st_reg;
    hli_bank_state_t st_next;

    // set wins over clear in the same cycle
    always_comb begin
        st_next       = st_reg;
        st_next.flags = (st_reg.flags & ~clr_mask) | set_mask;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;

endmodule : hli_flag_bank
`default_nettype wire

// ---- hli_octet_watch.sv ----
// Purpose: watch the incoming data link bits for the flag octet and aborts
// Assumes: one bit per cycle where bit_valid is high, oldest bit first
// Notes:   outputs are one-cycle pulses, registered
`timescale 1ns/10ps
`default_nettype none
module hli_octet_watch #(
    parameter int unsigned ONES_LIMIT = hli_pkg::ABORT_ONES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // incoming data link channel
    input  wire logic bit_valid,
    input  wire logic bit_data,
    // detections
    output logic      flag_octet_seen,
    output logic      abort_seen
);

    if (ONES_LIMIT < 1 || ONES_LIMIT > 15) begin : g_limit_check
        $error("hli_octet_watch: ONES_LIMIT must be 1 to 15");
    end

    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] ones;
        logic       flag_hit;
        logic       abort_hit;
    } hli_watch_state_t;

    hli_watch_state_t st_reg;
    hli_watch_state_t st_next;

    // newest bit enters at bit 0, so the octet reads in arrival order
    always_comb begin
        st_next           = st_reg;
        st_next.flag_hit  = 1'b0;
        st_next.abort_hit = 1'b0;
        if (bit_valid) begin
            st_next.shift = {st_reg.shift[6:0], bit_data};
            if (st_next.shift == hli_pkg::FLAG_OCTET) begin
                st_next.flag_hit = 1'b1; // [R5]
            end
            if (!bit_data) begin
                st_next.ones = 4'h0;
            end else if (st_reg.ones != 4'(ONES_LIMIT)) begin
                st_next.ones = st_reg.ones + 4'h1;
                // one pulse per run, on the seventh one in a row
                if (st_next.ones == 4'(ONES_LIMIT)) begin
                    st_next.abort_hit = 1'b1; // [R4]
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_octet_seen = st_reg.flag_hit;
    assign abort_seen      = st_reg.abort_hit;

endmodule : hli_octet_watch
`default_nettype wire

// ---- hli_top.sv ----
// Purpose: interrupt status and enable logic of the second link controller
// Assumes: event inputs are one-cycle pulses synchronous to mclk
// Notes:   read data appear one cycle after the read strobe; irq registered
//
// Behaviour
// [R1] Receive end flag (bit 3) sets on a complete message or a full buffer.
// [R2] Event flags hold until a status read or a written one clears them.
// [R3] Frame check error flag (bit 2) sets on a check sequence mismatch.
// [R4] Abort flag (bit 1) sets on seven consecutive ones on the link.
// [R5] Flag octet flag (bit 0) sets whenever the link carries 0x7e.
// [R6] Software takes flag octet plus receive end as a whole message.
// [R7] Enable bit 6 lets transmit start raise the interrupt.
// [R8] Enable bit 5 lets receive start raise the interrupt.
// [R9] Enable bit 4 lets transmit end raise the interrupt.
// [R10] Enable bit 3 lets receive end raise the interrupt.
// [R11] Enable bits are read/write, one enables, zero disables, reset zero.
// [R12] Enable bit 7 is reserved, does nothing and reads zero.
// [R13] Enable bits 2, 1, 0 gate check error, abort and flag octet events.
// [R14] Status bits 6 and 4 hold transmit start and end, cleared alike.
// [R15] The interrupt is high while any enabled status flag is set.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module hli_top (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // register port
    input  wire logic [hli_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [hli_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [hli_pkg::DATA_W-1:0]  reg_rdata,
    // receive side of the second link controller
    input  wire logic                        rx_msg_start,
    input  wire logic                        rx_msg_done,
    input  wire logic                        rx_buf_full,
    input  wire logic                        rx_fcs_mismatch,
    input  wire logic                        rx_msg_type,
    // incoming data link channel bits
    input  wire logic                        dl_bit_valid,
    input  wire logic                        dl_bit,
    // transmit side of the second link controller
    input  wire logic                        tx_msg_start,
    input  wire logic                        tx_msg_done,
    // interrupt request
    output logic                             irq
);

    localparam int unsigned NE = hli_pkg::NUM_EVENTS;

    // registered state of the block
    typedef struct packed {
        logic [7:0]    enable;
        logic          msg_type;
        logic [7:0]    rdata;
        logic          irq;
    } hli_top_state_t;

    hli_top_state_t st_reg;
    hli_top_state_t st_next;

    // pattern detector outputs
    logic          flag_octet_seen;
    logic          abort_seen;

    // event and flag vectors
    logic [NE-1:0] ev_set;
    logic [NE-1:0] ev_clr;
    logic [NE-1:0] flags;
    logic [NE-1:0] pending;

    // decoded strobes
    logic          wr_status;
    logic          wr_enable;
    logic          rd_status;

    // register address match
    function automatic logic hit(
        input logic [hli_pkg::ADDR_W-1:0] a,
        input logic [7:0]                 ofs
    );
        hit = (a == ofs);
    endfunction : hit

    // status word as software sees it: message type above the flags
    function automatic logic [7:0] status_word(
        input logic          mtype,
        input logic [NE-1:0] f
    );
        status_word = {mtype, f};
    endfunction : status_word

    // the two link pattern detections come from the serial watcher
    hli_octet_watch #(
        .ONES_LIMIT (hli_pkg::ABORT_ONES)
    ) u_watch (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .bit_valid       (dl_bit_valid),
        .bit_data        (dl_bit),
        .flag_octet_seen (flag_octet_seen),
        .abort_seen      (abort_seen)
    );

    // strobe decode
    assign wr_status = reg_wr & hit(reg_addr, hli_pkg::OFS_EVENT_STATUS);
    assign wr_enable = reg_wr & hit(reg_addr, hli_pkg::OFS_EVENT_ENABLE);
    assign rd_status = reg_rd & hit(reg_addr, hli_pkg::OFS_EVENT_STATUS);

    // hardware events into their status positions
    always_comb begin
        ev_set                         = '0;
        ev_set[hli_pkg::BIT_TX_START]  = tx_msg_start;                 // [R14]
        ev_set[hli_pkg::BIT_RX_START]  = rx_msg_start;
        ev_set[hli_pkg::BIT_TX_END]    = tx_msg_done;                  // [R14]
        ev_set[hli_pkg::BIT_RX_END]    = rx_msg_done | rx_buf_full;    // [R1]
        ev_set[hli_pkg::BIT_FCS_ERR]   = rx_fcs_mismatch;              // [R3]
        ev_set[hli_pkg::BIT_ABORT]     = abort_seen;                   // [R4]
        ev_set[hli_pkg::BIT_FLAG_OCTET] = flag_octet_seen;             // [R5]
    end

    // a status read clears every flag it returned; a written one clears that flag.
    // flags set in the read cycle are not in the snapshot, and set wins,
    // so they survive to the next read
    always_comb begin
        ev_clr = '0;
        if (rd_status) begin
            ev_clr = flags;                                            // [R2]
        end
        if (wr_status) begin
            ev_clr = ev_clr | reg_wdata[NE-1:0];                       // [R2]
        end
    end

    // sticky flags, also feeding the status word for [R6] pairing
    hli_flag_bank #(
        .WIDTH (NE)
    ) u_flags (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_mask (ev_set),
        .clr_mask (ev_clr),
        .flags    (flags)
    );

    // enabled flags; bit 7 of enable has no event behind it
    assign pending = flags & st_reg.enable[NE-1:0];       // [R7] [R8] [R9]

    // next-state: enable writes, read data and the interrupt request
    always_comb begin
        st_next          = st_reg;
        st_next.msg_type = rx_msg_type;
        if (wr_enable) begin
            // reserved bit 7 is dropped, so it reads back zero
            st_next.enable = reg_wdata & hli_pkg::ENABLE_RW_MASK; // [R11] [R12]
        end
        // read data stand for one cycle only, zero otherwise
        st_next.rdata = hli_pkg::RST_RDATA;
        if (reg_rd) begin
            case (1'b1)
                hit(reg_addr, hli_pkg::OFS_EVENT_STATUS): begin
                    st_next.rdata = status_word(st_reg.msg_type, flags);
                end
                hit(reg_addr, hli_pkg::OFS_EVENT_ENABLE): begin
                    st_next.rdata = st_reg.enable;                 // [R11]
                end
                hit(reg_addr, hli_pkg::OFS_PENDING): begin
                    st_next.rdata = {1'b0, pending};
                end
                default: begin
                    st_next.rdata = hli_pkg::RST_RDATA;
                end
            endcase
        end
        // level request from the registered flags, one cycle behind them;
        // check error, abort and flag octet gate through bits 2..0
        st_next.irq = |pending;                       // [R10] [R13] [R15]
    end

    // all control state resets to constants
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.enable   <= hli_pkg::RST_ENABLE;                   // [R11]
            st_reg.msg_type <= 1'b0;
            st_reg.rdata    <= hli_pkg::RST_RDATA;
            st_reg.irq      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs come straight from flip-flops
    assign reg_rdata = st_reg.rdata;
    assign irq       = st_reg.irq;

endmodule : hli_top
`default_nettype wire

// ---- hli_assertions.sv ----
// Purpose: port-level assertions for hli_top
// Assumes: enable changes only through the register port
// Notes:   helper logic mirrors the enable register and the link bits
`timescale 1ns/10ps
`default_nettype none
module hli_assertions (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // link controller events
    input wire logic       rx_msg_start,
    input wire logic       rx_msg_done,
    input wire logic       rx_buf_full,
    input wire logic       rx_fcs_mismatch,
    input wire logic       rx_msg_type,
    input wire logic       dl_bit_valid,
    input wire logic       dl_bit,
    input wire logic       tx_msg_start,
    input wire logic       tx_msg_done,
    input wire logic       irq
);
    logic [7:0] en_q;
    logic [2:0] ones;
    logic [6:0] sh;
    wire logic sta_rd = reg_rd && reg_addr == hli_pkg::OFS_EVENT_STATUS;
    wire logic quiet = !(rx_msg_start | rx_msg_done | rx_buf_full |
        rx_fcs_mismatch | tx_msg_start | tx_msg_done | dl_bit_valid);
    wire logic abort_ev = dl_bit_valid && dl_bit && ones == 3'h6;
    wire logic octet_ev = dl_bit_valid &&
        {sh, dl_bit} == hli_pkg::FLAG_OCTET;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ones count saturates so an abort is seen once per run of ones
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= 8'h00;
            ones <= 3'h0;
            sh   <= 7'h00;
        end else begin
            if (reg_wr && reg_addr == hli_pkg::OFS_EVENT_ENABLE)
                en_q <= reg_wdata & hli_pkg::ENABLE_RW_MASK;
            if (dl_bit_valid) begin
                sh   <= {sh[5:0], dl_bit};
                ones <= !dl_bit ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
            end
        end
    end

    // event to interrupt latencies and register behaviour
    rdata_idle_zero_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    rx_end_raise_a: assert property (
        (rx_msg_done | rx_buf_full) && en_q[3] |-> ##2 irq)
        else $error("receive end did not raise irq");
    fcs_raise_a: assert property (
        rx_fcs_mismatch && en_q[2] |-> ##2 irq)
        else $error("check error did not raise irq");
    start_raise_a: assert property (
        (tx_msg_start && en_q[6]) || (rx_msg_start && en_q[5])
        |-> ##2 irq)
        else $error("start event did not raise irq");
    tx_end_raise_a: assert property (
        tx_msg_done && en_q[4] |-> ##2 irq)
        else $error("transmit end did not raise irq");
    abort_raise_a: assert property (
        abort_ev && en_q[1] |-> ##3 irq)
        else $error("abort did not raise irq");
    octet_raise_a: assert property (
        octet_ev && en_q[0] |-> ##3 irq)
        else $error("flag octet did not raise irq");
    masked_quiet_a: assert property (
        $past(en_q) == 8'h00 |-> !irq)
        else $error("irq high with all enables off");
    enable_readback_a: assert property (
        reg_rd && reg_addr == hli_pkg::OFS_EVENT_ENABLE
        |=> reg_rdata == $past(en_q))
        else $error("enable read back wrong");
    // back-to-back status reads: the second must find the flags cleared
    read_clears_a: assert property (
        (sta_rd && quiet && !$past(dl_bit_valid)) ##1 sta_rd
        |=> reg_rdata[6:0] == 7'h00)
        else $error("status read did not clear flags");
    cover property ($rose(irq));
    cover property (sta_rd ##1 sta_rd);
    cover property (abort_ev);
    cover property (octet_ev);
endmodule : hli_assertions

bind hli_top hli_assertions hli_assertions_inst (.mclk(mclk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_msg_start(rx_msg_start), .rx_msg_done(rx_msg_done),
    .rx_buf_full(rx_buf_full), .rx_fcs_mismatch(rx_fcs_mismatch),
    .rx_msg_type(rx_msg_type), .dl_bit_valid(dl_bit_valid),
    .dl_bit(dl_bit), .tx_msg_start(tx_msg_start),
    .tx_msg_done(tx_msg_done), .irq(irq));
`default_nettype wire

// ---- testbench.sv ----
// Purpose: directed register-level bench for hli_top
// Assumes: fixed event, read and irq latencies of the block
// Notes:   message type input tied low, so status bit 7 reads zero
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       mclk, sys_rst, reg_wr, reg_rd, dl_v, dl_b, full, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, m;
    logic [6:2] ev;
    int         errors, num_checks;
    localparam logic [7:0] STA = hli_pkg::OFS_EVENT_STATUS;
    localparam logic [7:0] ENA = hli_pkg::OFS_EVENT_ENABLE;
    localparam logic [7:0] PND = hli_pkg::OFS_PENDING;

    hli_top hli_top_inst (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_msg_start(ev[5]),
        .rx_msg_done(ev[3]), .rx_buf_full(full),
        .rx_fcs_mismatch(ev[2]), .rx_msg_type(1'b0), .dl_bit_valid(dl_v),
        .dl_bit(dl_b), .tx_msg_start(ev[6]), .tx_msg_done(ev[4]),
        .irq(irq));

    // compare and count
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // register port cycles; strobes drop at the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, exp);
    endtask : rd

    // two reads with no gap; the second sees what the first left behind
    task automatic rd2(input logic [7:0] a, input logic [7:0] e1,
                       input logic [7:0] e2);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        #1 check("reg_rdata", reg_rdata, e1);
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, e2);
    endtask : rd2

    // one-cycle event pulse; index 1 is the buffer-full input
    task automatic pulse(input int i);
        @(posedge mclk);
        if (i == 1) full <= 1'b1;
        else ev[i] <= 1'b1;
        @(posedge mclk);
        full <= 1'b0;
        ev   <= '0;
    endtask : pulse

    // one octet on the link, first bit is the msb, then irq has settled
    task automatic send(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            @(posedge mclk);
            dl_v <= 1'b1;
            dl_b <= b[k];
        end
        @(posedge mclk);
        dl_v <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask : send

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // main sequence
    initial begin
        {sys_rst, reg_wr, reg_rd, dl_v, dl_b, full} = 6'h20;
        {reg_addr, reg_wdata, ev, errors, num_checks} = '0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(STA, 8'h00);
        rd(ENA, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
        wr(ENA, 8'hff);
        rd(ENA, 8'h7f);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
        rd(ENA, 8'h7f);
        wr(ENA, 8'h00);
        rd(ENA, 8'h00);
        $display("test registers done");
        // each event masked, then unmasked and cleared by a written one
        for (int i = 1; i <= 6; i++) begin
            m = 8'h01 << (i == 1 ? 3 : i);
            pulse(i);
            repeat (2) @(posedge mclk);
            #1 check("irq", {7'h00, irq}, 8'h00);
            rd(PND, 8'h00);
            rd(STA, m);
            rd(STA, 8'h00);
            wr(ENA, m);
            pulse(i);
            repeat (2) @(posedge mclk);
            #1 check("irq", {7'h00, irq}, 8'h01);
            rd(PND, m);
            wr(STA, m);
            repeat (2) @(posedge mclk);
            #1 check("irq", {7'h00, irq}, 8'h00);
            wr(ENA, 8'h00);
        end
        $display("test events done");
        // link patterns: flag octet, then a run of ones
        wr(ENA, 8'h03);
        send(8'h7e);
        check("irq", {7'h00, irq}, 8'h01);
        rd(STA, 8'h01);
        send(8'hff);
        check("irq", {7'h00, irq}, 8'h01);
        rd(STA, 8'h02);
        pulse(3);
        send(8'h7e);
        rd2(STA, 8'h09, 8'h00);
        $display("test link done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
